// >>> shared/mdc_pkg.sv
// package for the serial command logic of a 16-channel converter
// assumes one control clock domain plus the host's serial clock
package mdc_pkg;

    localparam int NCH          = 16;
    localparam int CODE_W       = 16;
    localparam int FRAME_BITS   = 24;
    localparam int CNT_W        = 5;
    localparam int GROUP_CH     = 8;
    localparam int SYNC_STAGES  = 3;

    // frame field positions
    localparam int CMD_MSB      = 23;
    localparam int ADDR_MSB     = 19;
    localparam int DATA_MSB     = 15;
    localparam int GROUP_BIT    = 19;
    localparam int CHAIN_BIT    = 0;

    // command codes
    localparam logic [3:0] CMD_NOP       = 4'h0;
    localparam logic [3:0] CMD_WR_INPUT  = 4'h1;
    localparam logic [3:0] CMD_UPD_DAC   = 4'h2;
    localparam logic [3:0] CMD_WR_UPD    = 4'h3;
    localparam logic [3:0] CMD_POWER     = 4'h4;
    localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
    localparam logic [3:0] CMD_CHAIN     = 4'h8;
    localparam logic [3:0] CMD_READBACK  = 4'h9;
    localparam logic [3:0] CMD_NOP_CHAIN = 4'hF;

    // power mode field values
    localparam logic [1:0] PM_NORMAL     = 2'h0;
    localparam logic [1:0] PM_1K_GND     = 2'h1;

    // reset values and readback padding
    localparam logic [15:0] MASK_RST     = 16'h0000;
    localparam logic        CHAIN_RST    = 1'b0;
    localparam logic [15:0] CODE_RST     = 16'h0000;
    localparam logic [1:0]  PM_RST       = 2'h0;
    localparam logic [3:0]  RB_PAD       = 4'h0;

    typedef struct packed {
        logic [3:0]  command_field;
        logic [3:0]  channel_address_field;
        logic [15:0] data;
    } mdc_frame_s;

    typedef enum logic [1:0] {
        RB_IDLE  = 2'b00,
        RB_ARMED = 2'b01,
        RB_SEND  = 2'b11
    } mdc_rb_e;

endpackage

// >>> core/mdc_serial_ctrl.sv
// serial command logic: frame capture, chain/readback output,
// power modes, input and converter register banks with load mask
// assumes sclk, sync_n, sdi and load_dac_n come straight from pins
`timescale 1ns/1ps
module mdc_serial_ctrl
    import mdc_pkg::*;
(
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         sclk,
    input  wire logic                         sync_n,
    input  wire logic                         sdi,
    input  wire logic                         load_dac_n,
    output logic                              sdo,
    output logic                              sdo_oe,
    output logic                              sdo_keep,
    output logic                              chain_enable,
    output logic [NCH-1:0][CODE_W-1:0]        dac_value,
    output logic [NCH-1:0][1:0]               power_mode
);

    // ---------------- link domain (sclk) ----------------
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic [CNT_W-1:0]      bit_cnt;
    logic [CNT_W-1:0]      next_bit_cnt;
    logic                  next_sdo;
    logic                  link_clr;

    // ref-domain state read here only while sync_n is low; it changes
    // only while sync_n is high, so the frame itself is the handshake
    logic                  rb_active;
    logic [FRAME_BITS-1:0] rb_word;

    assign link_clr = rst | sync_n;

    always_comb begin
        next_shreg   = shreg;
        next_bit_cnt = bit_cnt;
        if (!sync_n) begin
            next_shreg = {shreg[FRAME_BITS-2:0], sdi};
            if (bit_cnt != CNT_W'(FRAME_BITS)) begin
                next_bit_cnt = bit_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            shreg <= '0;
        end else begin
            shreg <= next_shreg;
        end
    end

    always_ff @(negedge sclk or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    always_comb begin
        // past 24 bits the shift register ripples through
        next_sdo = shreg[FRAME_BITS-1];
        if (rb_active && bit_cnt < CNT_W'(FRAME_BITS)) begin
            next_sdo = rb_word[CNT_W'(FRAME_BITS-1) - bit_cnt];
        end
    end

    // no update while sync_n is high: the pin holds the last bit
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            sdo <= 1'b0;
        end else if (!sync_n) begin
            sdo <= next_sdo;
        end
    end

    // ---------------- control domain (ref_clk) ----------------
    logic [1:0] pin_raw;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic [1:0] next_lvl;
    logic [1:0] rise;
    logic [1:0] fall;

    assign pin_raw = {load_dac_n, sync_n};

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pin
            always_comb begin
                next_lvl[p] = lvl[p];
                rise[p]     = 1'b0;
                fall[p]     = 1'b0;
                if (s2[p] == s3[p] && s3[p] != lvl[p]) begin
                    next_lvl[p] = s3[p];
                    rise[p]     = s3[p];
                    fall[p]     = ~s3[p];
                end
            end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    s1[p]  <= 1'b1;
                    s2[p]  <= 1'b1;
                    s3[p]  <= 1'b1;
                    lvl[p] <= 1'b1;
                end else begin
                    s1[p]  <= pin_raw[p];
                    s2[p]  <= s1[p];
                    s3[p]  <= s2[p];
                    lvl[p] <= next_lvl[p];
                end
            end
        end
    endgenerate

    logic frame_done;
    logic frame_start;
    logic ld_fall;
    logic ld_low;

    assign frame_done  = rise[0];
    assign frame_start = fall[0];
    assign ld_fall     = fall[1];
    assign ld_low      = ~lvl[1];

    // shreg is stable here: sync_n is high and shifting is gated off
    mdc_frame_s fr;
    assign fr = mdc_frame_s'(shreg);

    logic [NCH-1:0][CODE_W-1:0] in_reg;
    logic [NCH-1:0][CODE_W-1:0] next_in_reg;
    logic [NCH-1:0][CODE_W-1:0] next_dac;
    logic [NCH-1:0][1:0]        next_pm;
    logic [NCH-1:0]             mask;
    logic [NCH-1:0]             next_mask;
    logic                       next_chain;
    mdc_rb_e                    rb_state;
    mdc_rb_e                    next_rb_state;
    logic [3:0]                 rb_chan;
    logic [3:0]                 next_rb_chan;
    logic [FRAME_BITS-1:0]      next_rb_word;
    logic                       next_oe;

    logic [3:0] cmd;
    logic [3:0] addr;
    assign cmd  = fr.command_field;
    assign addr = fr.channel_address_field;

    // frame executes at any bit count, partial or not
    always_comb begin
        next_mask    = mask;
        next_chain   = chain_enable;
        next_rb_chan = rb_chan;
        next_rb_word = rb_word;
        if (frame_done) begin
            case (cmd)
                CMD_LOAD_MASK: next_mask = fr.data;
                CMD_CHAIN:     next_chain = fr.data[CHAIN_BIT];
                CMD_READBACK: begin
                    next_rb_chan = addr;
                    next_rb_word = {RB_PAD, RB_PAD, in_reg[addr]};
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_rb_state = rb_state;
        case (rb_state)
            RB_IDLE: begin
            end
            RB_ARMED: begin
                if (frame_start) begin
                    next_rb_state = RB_SEND;
                end
            end
            RB_SEND: begin
                if (frame_done) begin
                    next_rb_state = RB_IDLE;
                end
            end
            default: next_rb_state = RB_IDLE;
        endcase
        if (frame_done && cmd == CMD_READBACK) begin
            next_rb_state = RB_ARMED;
        end
    end

    assign rb_active = (rb_state != RB_IDLE);

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic hit;
            assign hit = frame_done && addr == 4'(c);
            always_comb begin
                next_in_reg[c] = in_reg[c];
                next_dac[c]    = dac_value[c];
                next_pm[c]     = power_mode[c];
                if (hit && (cmd == CMD_WR_INPUT || cmd == CMD_WR_UPD)) begin
                    next_in_reg[c] = fr.data;
                end
                if (hit && cmd == CMD_WR_UPD) begin
                    next_dac[c] = fr.data;
                end
                // low load pin makes the input stage transparent for unmasked channels
                if (hit && cmd == CMD_WR_INPUT && ld_low && !mask[c]) begin
                    next_dac[c] = fr.data;
                end
                if (frame_done && cmd == CMD_UPD_DAC && fr.data[c]) begin
                    next_dac[c] = in_reg[c];
                end
                // edge copy sees the freshly written input value
                if (ld_fall && !mask[c]) begin
                    next_dac[c] = next_in_reg[c];
                end
                if (frame_done && cmd == CMD_POWER &&
                    fr.channel_address_field[GROUP_BIT-16] ==
                    1'((c / GROUP_CH))) begin
                    next_pm[c] = fr.data[2*(c%GROUP_CH) +: 2];
                end
            end
            // power mode never gates register updates
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    in_reg[c]     <= CODE_RST;
                    dac_value[c]  <= CODE_RST;
                    power_mode[c] <= PM_RST;
                end else begin
                    in_reg[c]     <= next_in_reg[c];
                    dac_value[c]  <= next_dac[c];
                    power_mode[c] <= next_pm[c];
                end
            end
        end
    endgenerate

    // output enable lags the pin by the synchroniser delay
    assign next_oe = ~lvl[0] & (chain_enable | rb_state == RB_SEND);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask         <= MASK_RST;
            chain_enable <= CHAIN_RST;
            rb_state     <= RB_IDLE;
            rb_chan      <= 4'h0;
            rb_word      <= '0;
            sdo_oe       <= 1'b0;
            sdo_keep     <= 1'b0;
        end else begin
            mask         <= next_mask;
            chain_enable <= next_chain;
            rb_state     <= next_rb_state;
            rb_chan      <= next_rb_chan;
            rb_word      <= next_rb_word;
            sdo_oe       <= next_oe;
            sdo_keep     <= lvl[0];
        end
    end

endmodule

// >>> test/mdc_serial_ctrl_assertions.sv
// port-level checker for the serial command logic
// assumes it is bound onto every mdc_serial_ctrl instance
`timescale 1ns/1ps
module mdc_serial_ctrl_assertions
    import mdc_pkg::*;
(
    input wire logic                      ref_clk,
    input wire logic                      rst,
    input wire logic                      sclk,
    input wire logic                      sync_n,
    input wire logic                      sdi,
    input wire logic                      load_dac_n,
    input wire logic                      sdo,
    input wire logic                      sdo_oe,
    input wire logic                      sdo_keep,
    input wire logic                      chain_enable,
    input wire logic [NCH-1:0][CODE_W-1:0] dac_value,
    input wire logic [NCH-1:0][1:0]       power_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_SDO_ON_RISE: assert property ($changed(sdo) |-> $rose(sclk))
        else $error("sdo moved without a rising sclk");
    AST_SDO_IDLE: assert property (sync_n && $past(sync_n, 3) |-> $stable(sdo))
        else $error("sdo moved between frames");
    AST_KEEP_AFTER_SYNC: assert property ($rose(sync_n) |-> ##[1:6] (sdo_keep && !sdo_oe))
        else $error("keeper not taken after frame end");
    AST_KEEP_OFF_IN_FRAME: assert property ($fell(sync_n) |-> ##[1:6] !sdo_keep)
        else $error("keeper held inside a frame");
    AST_OE_NOT_KEEP: assert property (sdo_oe |-> !sdo_keep)
        else $error("strong drive and keeper together");
    AST_EXEC_AFTER_RISE: assert property (($changed(dac_value) || $changed(power_mode) || $changed(chain_enable)) |-> sync_n && $past(sync_n, 2))
        else $error("state changed inside a frame");
    AST_PM_ONE_GROUP: assert property ($changed(power_mode) |-> (power_mode[7:0] == $past(power_mode[7:0])) || (power_mode[15:8] == $past(power_mode[15:8])))
        else $error("both power groups changed at once");
    AST_PM_KEEPS_DAC: assert property ($changed(power_mode) |-> $stable(dac_value))
        else $error("power change disturbed converter values");
    AST_CHAIN_ALONE: assert property ($changed(chain_enable) |-> $stable(dac_value) && $stable(power_mode))
        else $error("chain change disturbed other state");

    COV_CHAIN: cover property ($rose(chain_enable));
    COV_POWER: cover property ($changed(power_mode));
    COV_READBACK_OE: cover property ($rose(sdo_oe) && !chain_enable);
    COV_LOAD: cover property ($fell(load_dac_n) ##[1:6] $changed(dac_value));
endmodule

bind mdc_serial_ctrl mdc_serial_ctrl_assertions chk_u (.ref_clk, .rst, .sclk,
    .sync_n, .sdi, .load_dac_n, .sdo, .sdo_oe, .sdo_keep, .chain_enable,
    .dac_value, .power_mode);

// >>> test/mdc_host_model.sv
// host serial controller model: frames and load pin pulses
// assumes the converter samples sdi on falling sclk, sclk idles low
`timescale 1ns/1ps
module mdc_host_model (
    output logic      sclk,
    output logic      sync_n,
    output logic      sdi,
    output logic      load_dac_n,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b0;
        load_dac_n = 1'b1;
    end
    // clock stands still between frames; sdi flips so a stale bit shows
    task automatic send(input logic [47:0] w, input int n,
                        output logic [23:0] r);
        r = 24'h000000;
        sync_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #16 sdi <= w[i];
            #16 sclk <= 1'b1;
            #32 r = {r[22:0], sdo};
            sclk <= 1'b0;
        end
        #32 sync_n <= 1'b1;
        sdi <= ~sdi;
        #200;
    endtask
    task automatic pulse_load();
        load_dac_n <= 1'b0;
        #100 load_dac_n <= 1'b1;
        #100;
    endtask
    task automatic set_load(input logic v);
        load_dac_n <= v;
        #200;
    endtask
endmodule

// >>> test/testbench.sv
// self-checking bench: driver notes expectations, monitor compares
// assumes mdc_host_model drives the serial pins and load pin
`timescale 1ns/1ps
module testbench;
    import mdc_pkg::*;
    typedef struct {int kind; int ch; logic [31:0] val;} mdc_note_s;
    logic                        ref_clk, rst;
    logic                        sclk, sync_n, sdi, load_dac_n;
    logic                        sdo, sdo_oe, sdo_keep, chain_enable;
    logic [NCH-1:0][CODE_W-1:0]  dac_value;
    logic [NCH-1:0][1:0]         power_mode;
    logic [23:0]                 rx;
    logic [15:0]                 v, w, d;
    logic [3:0]                  ch;
    logic [31:0]                 pm;
    mdc_note_s                   notes[$];
    string nm[4] = '{"dac_value", "power_mode", "chain_enable", "readback"};
    int                          fail_count = 0;
    int                          checks = 0;
    int                          cycles = 0;
    event                        chk;

    mdc_serial_ctrl dut_u (.ref_clk, .rst, .sclk, .sync_n, .sdi,
        .load_dac_n, .sdo, .sdo_oe, .sdo_keep, .chain_enable,
        .dac_value, .power_mode);
    mdc_host_model host_u (.sclk, .sync_n, .sdi, .load_dac_n, .sdo);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a long wait covers the 3 to 4 cycle update lag with margin
    task automatic expect_val(input int k, input int c, input logic [31:0] e,
                              input string t);
        notes.push_back('{k, c, e});
        repeat (8) @(posedge ref_clk);
        #1 ->chk;
        #1 $display("test %s done", t);
    endtask

    task automatic frame(input logic [3:0] c, input logic [3:0] a,
                         input logic [15:0] x);
        host_u.send({24'h000000, c, a, x}, 24, rx);
    endtask

    always @(chk) begin
        mdc_note_s n;
        logic [31:0] seen;
        n = notes.pop_front();
        case (n.kind)
            0: seen = {16'h0000, dac_value[n.ch]};
            1: seen = power_mode;
            2: seen = {31'h0, chain_enable};
            default: seen = {8'h00, rx};
        endcase
        checks++;
        if (seen !== n.val) begin
            $display("unexpected %s exp %h seen %h", nm[n.kind], n.val, seen);
            fail_count++;
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        rst = 1'b1;
        void'($urandom(1936));
        ch = 4'($urandom);
        v = 16'($urandom);
        w = 16'($urandom);
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        expect_val(2, 0, 0, "reset chain");
        expect_val(0, 5, 0, "reset dac");
        frame(CMD_WR_UPD, ch, v);
        expect_val(0, ch, v, "direct write");
        frame(CMD_WR_INPUT, ch, w);
        expect_val(0, ch, v, "deferred hold");
        host_u.pulse_load();
        expect_val(0, ch, w, "deferred load");
        frame(CMD_LOAD_MASK, ~ch, 16'h0001 << ch);
        frame(CMD_WR_INPUT, ch, v);
        host_u.pulse_load();
        expect_val(0, ch, w, "masked load");
        frame(CMD_LOAD_MASK, ch, 16'h0000);
        host_u.set_load(1'b0);
        frame(CMD_WR_INPUT, ch, ~w);
        expect_val(0, ch, {16'h0000, ~w}, "load low write");
        host_u.set_load(1'b1);
        frame(CMD_READBACK, ch, 16'($urandom));
        frame(CMD_NOP, 4'h0, 16'h0000);
        expect_val(3, 0, {8'h00, 8'h00, ~w}, "readback");
        pm = power_mode;
        // channel c owns pm bits 2c+1:2c, so the upper group is pm[31:16]
        d = (16'($urandom) & 16'h5555) | 16'h0004;
        pm[31:16] = d;
        frame(CMD_POWER, 4'h8, d);
        expect_val(1, 0, pm, "power upper");
        d = 16'($urandom) & 16'h5555;
        pm[15:0] = d;
        frame(CMD_POWER, 4'h7, d);
        expect_val(1, 0, pm, "power lower");
        frame(CMD_WR_UPD, 4'h9, v);
        expect_val(0, 9, v, "write powered down");
        frame(CMD_WR_INPUT, 4'h9, w);
        frame(CMD_UPD_DAC, 4'h0, 16'h0200);
        expect_val(0, 9, w, "update from input");
        host_u.send({20'h00000, 4'hA, CMD_WR_UPD, ch, ~v}, 28, rx);
        expect_val(0, ch, {16'h0000, ~v}, "long frame");
        frame(CMD_CHAIN, 4'h0, 16'h0001);
        expect_val(2, 0, 1, "chain on");
        host_u.send({CMD_WR_UPD, 4'h3, w, CMD_NOP_CHAIN, 20'h00000}, 48, rx);
        expect_val(3, 0, {8'h00, CMD_WR_UPD, 4'h3, w}, "ripple");
        frame(CMD_CHAIN, 4'h0, 16'h0000);
        expect_val(2, 0, 0, "chain off");
        finish_test();
    end
endmodule
